//--- include/dac_ctrl_consts.svh
// Register offsets, field positions and reset values of the converter control bank
`ifndef DAC_CTRL_CONSTS_SVH
`define DAC_CTRL_CONSTS_SVH

// ==========================================
// Register offsets
`define OFS_CONVERTER_POWER_DOWNS   12'h011
`define OFS_PAIR_POWER_DOWN_MASKS   12'h012
`define OFS_AMP_AND_TX_ENABLE_CTRL  12'h013
`define OFS_OUTPUT_DELAY_TRIM       12'h014
`define OFS_PLL_EVENT_ENABLES       12'h01f

// ==========================================
// Field positions
`define BIT_REFERENCE_POWER_DOWN    7
`define BIT_CONV0_POWER_DOWN        6
`define BIT_CONV1_POWER_DOWN        5
`define BIT_CONV2_POWER_DOWN        4
`define BIT_CONV3_POWER_DOWN        3
`define BIT_UPPER_PAIR_MASK         7
`define BIT_LOWER_PAIR_MASK         6
`define BIT_AMP_SRC_PROTECT_ERROR   6
`define BIT_AMP_SRC_TX_STATE_MACH   5
`define BIT_AMP_SRC_BLANKING_MACH   4
`define BIT_AMP_SRC_REGISTER        3
`define BIT_AMP_REGISTER_LEVEL      2
`define BIT_TX_OVERRIDE_SELECT      1
`define BIT_TX_OVERRIDE_LEVEL       0
`define BIT_CONV_PLL_UNLOCK_EN      5
`define BIT_CONV_PLL_LOCKED_EN      4
`define BIT_LINK_PLL_UNLOCK_EN      3
`define BIT_LINK_PLL_LOCKED_EN      2

// ==========================================
// Reset values, storage masks and the delay trim width
`define RST_CONVERTER_POWER_DOWNS   8'hf8
`define RST_PAIR_POWER_DOWN_MASKS   8'h00
`define RST_AMP_AND_TX_ENABLE_CTRL  8'h20
`define RST_OUTPUT_DELAY_TRIM       4'h8
`define RST_PLL_EVENT_ENABLES       8'h00
`define MASK_CONVERTER_POWER_DOWNS  8'hf8
`define MASK_AMP_AND_TX_ENABLE_CTRL 8'h7f
`define DELAY_TRIM_WIDTH            4

`endif

//--- include/dac_ctrl_pkg.sv
// Types shared by the converter control bank
package dac_ctrl_pkg;

    // ==========================================
    // Power-down outputs
    typedef struct packed {
        logic       reference;
        logic [3:0] conv;
    } power_down_s;

    // ==========================================
    // Amplifier enable source selection
    typedef struct packed {
        logic protect_error;
        logic tx_state_machine;
        logic blanking_machine;
        logic register_src;
    } amp_src_s;

    // ==========================================
    // Lock reporting events
    typedef struct packed {
        logic conv_pll_unlock;
        logic conv_pll_locked;
        logic link_pll_unlock;
        logic link_pll_locked;
    } pll_event_s;

endpackage

//--- logic/dac_tx_power_pa_control.sv
// Converter power-down, amplifier enable, delay trim and lock-event control bank
`timescale 1ns/1ps
`include "dac_ctrl_consts.svh"

module dac_tx_power_pa_control (
    input  wire logic                          i_core_clk,
    input  wire logic                          i_reset,
    input  wire logic [11:0]                   i_reg_addr,
    input  wire logic                          i_reg_wr,
    input  wire logic                          i_reg_rd,
    input  wire logic [7:0]                    i_reg_wdata,
    output logic      [7:0]                    o_reg_rdata,
    output logic                               o_reg_rvalid,
    input  wire logic                          i_tx_enable_input_a,
    input  wire logic                          i_tx_enable_input_b,
    input  wire logic                          i_amp_protect_error,
    input  wire logic                          i_tx_machine_amp_on,
    input  wire logic                          i_blanking_amp_on,
    input  wire logic                          i_conv_pll_locked,
    input  wire logic                          i_link_pll_locked,
    output dac_ctrl_pkg::power_down_s          o_power_down,
    output logic                               o_amp_enable,
    output logic      [1:0]                    o_tx_enable,
    output logic      [`DELAY_TRIM_WIDTH-1:0]  o_group_delay_code,
    output dac_ctrl_pkg::pll_event_s           o_pll_event
);

    // ==========================================
    // Registers
    logic [7:0]                   converter_power_downs_r;
    logic [7:0]                   pair_power_down_masks_r;
    logic [7:0]                   amp_and_tx_enable_control_r;
    logic [`DELAY_TRIM_WIDTH-1:0] output_delay_trim_r;
    logic [7:0]                   pll_event_enables_r;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            converter_power_downs_r     <= `RST_CONVERTER_POWER_DOWNS;
            pair_power_down_masks_r     <= `RST_PAIR_POWER_DOWN_MASKS;
            amp_and_tx_enable_control_r <= `RST_AMP_AND_TX_ENABLE_CTRL;
            output_delay_trim_r         <= `RST_OUTPUT_DELAY_TRIM;
            pll_event_enables_r         <= `RST_PLL_EVENT_ENABLES;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `OFS_CONVERTER_POWER_DOWNS:
                    converter_power_downs_r <= i_reg_wdata & `MASK_CONVERTER_POWER_DOWNS;
                `OFS_PAIR_POWER_DOWN_MASKS:
                    pair_power_down_masks_r <= i_reg_wdata;
                `OFS_AMP_AND_TX_ENABLE_CTRL:
                    amp_and_tx_enable_control_r <= i_reg_wdata & `MASK_AMP_AND_TX_ENABLE_CTRL;
                `OFS_OUTPUT_DELAY_TRIM:
                    output_delay_trim_r <= i_reg_wdata[`DELAY_TRIM_WIDTH-1:0];
                `OFS_PLL_EVENT_ENABLES:
                    pll_event_enables_r <= i_reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // ==========================================
    // Read-back, one cycle after the strobe; unmapped offsets read zero
    logic [7:0] rdata_nxt;

    always_comb begin
        case (i_reg_addr)
            `OFS_CONVERTER_POWER_DOWNS:  rdata_nxt = converter_power_downs_r;
            `OFS_PAIR_POWER_DOWN_MASKS:  rdata_nxt = pair_power_down_masks_r;
            `OFS_AMP_AND_TX_ENABLE_CTRL: rdata_nxt = amp_and_tx_enable_control_r;
            `OFS_OUTPUT_DELAY_TRIM:      rdata_nxt = {4'h0, output_delay_trim_r};
            `OFS_PLL_EVENT_ENABLES:      rdata_nxt = pll_event_enables_r;
            default:                     rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rdata  <= i_reg_rd ? rdata_nxt : 8'h00;
            o_reg_rvalid <= i_reg_rd;
        end
    end

    // ==========================================
    // Pin synchronisers; first stage feeds only the second
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [1:0] lock_prev_r;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            sync1_r     <= 4'h0;
            sync2_r     <= 4'h0;
            lock_prev_r <= 2'h0;
        end else begin
            sync1_r     <= {i_conv_pll_locked, i_link_pll_locked,
                            i_tx_enable_input_b, i_tx_enable_input_a};
            sync2_r     <= sync1_r;
            lock_prev_r <= sync2_r[3:2];
        end
    end

    // ==========================================
    // Transmit enable after the register override
    logic [1:0] tx_enable_nxt;

    always_comb begin
        if (amp_and_tx_enable_control_r[`BIT_TX_OVERRIDE_SELECT]) begin
            tx_enable_nxt = {2{amp_and_tx_enable_control_r[`BIT_TX_OVERRIDE_LEVEL]}};
        end else begin
            tx_enable_nxt = sync2_r[1:0];
        end
    end

    // ==========================================
    // Power-down: pair masks add to, never release, the individual bits
    dac_ctrl_pkg::power_down_s power_down_nxt;
    logic                      lower_forced;
    logic                      upper_forced;

    always_comb begin
        lower_forced = pair_power_down_masks_r[`BIT_LOWER_PAIR_MASK] & ~tx_enable_nxt[0];
        upper_forced = pair_power_down_masks_r[`BIT_UPPER_PAIR_MASK] & ~tx_enable_nxt[1];
        power_down_nxt.reference = converter_power_downs_r[`BIT_REFERENCE_POWER_DOWN];
        power_down_nxt.conv[0] = converter_power_downs_r[`BIT_CONV0_POWER_DOWN] | lower_forced;
        power_down_nxt.conv[1] = converter_power_downs_r[`BIT_CONV1_POWER_DOWN] | lower_forced;
        power_down_nxt.conv[2] = converter_power_downs_r[`BIT_CONV2_POWER_DOWN] | upper_forced;
        power_down_nxt.conv[3] = converter_power_downs_r[`BIT_CONV3_POWER_DOWN] | upper_forced;
    end

    // ==========================================
    // Amplifier enable: on only when some source is selected and none asks off
    dac_ctrl_pkg::amp_src_s sel;
    dac_ctrl_pkg::amp_src_s want_on;
    logic                   amp_enable_nxt;

    always_comb begin
        sel.protect_error    = amp_and_tx_enable_control_r[`BIT_AMP_SRC_PROTECT_ERROR];
        sel.tx_state_machine = amp_and_tx_enable_control_r[`BIT_AMP_SRC_TX_STATE_MACH];
        sel.blanking_machine = amp_and_tx_enable_control_r[`BIT_AMP_SRC_BLANKING_MACH];
        sel.register_src     = amp_and_tx_enable_control_r[`BIT_AMP_SRC_REGISTER];
        want_on.protect_error    = ~i_amp_protect_error;
        want_on.tx_state_machine = i_tx_machine_amp_on;
        want_on.blanking_machine = i_blanking_amp_on;
        want_on.register_src     = amp_and_tx_enable_control_r[`BIT_AMP_REGISTER_LEVEL];
        // Safe default: no source selected leaves the amplifier off
        amp_enable_nxt = (|sel) & ~(|(sel & ~want_on));
    end

    // ==========================================
    // Lock edge reporting, gated by the enables
    dac_ctrl_pkg::pll_event_s event_nxt;

    always_comb begin
        event_nxt.conv_pll_unlock = pll_event_enables_r[`BIT_CONV_PLL_UNLOCK_EN]
                                    & lock_prev_r[1] & ~sync2_r[3];
        event_nxt.conv_pll_locked = pll_event_enables_r[`BIT_CONV_PLL_LOCKED_EN]
                                    & ~lock_prev_r[1] & sync2_r[3];
        event_nxt.link_pll_unlock = pll_event_enables_r[`BIT_LINK_PLL_UNLOCK_EN]
                                    & lock_prev_r[0] & ~sync2_r[2];
        event_nxt.link_pll_locked = pll_event_enables_r[`BIT_LINK_PLL_LOCKED_EN]
                                    & ~lock_prev_r[0] & sync2_r[2];
    end

    // ==========================================
    // Registered outputs
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_power_down       <= 5'h1f;
            o_amp_enable       <= 1'b0;
            o_tx_enable        <= 2'h0;
            o_group_delay_code <= `RST_OUTPUT_DELAY_TRIM;
            o_pll_event        <= 4'h0;
        end else begin
            o_power_down       <= power_down_nxt;
            o_amp_enable       <= amp_enable_nxt;
            o_tx_enable        <= tx_enable_nxt;
            o_group_delay_code <= output_delay_trim_r;
            o_pll_event        <= event_nxt;
        end
    end

endmodule // dac_tx_power_pa_control

//--- tb/dac_ctrl_asserts.sv
// Concurrent checks on the converter control bank ports
`timescale 1ns/1ps
`include "dac_ctrl_consts.svh"
module dac_ctrl_asserts (
    input wire logic                         i_core_clk,
    input wire logic                         i_reset,
    input wire logic [11:0]                  i_reg_addr,
    input wire logic                         i_reg_wr,
    input wire logic                         i_reg_rd,
    input wire logic [7:0]                   i_reg_wdata,
    input wire logic [7:0]                   o_reg_rdata,
    input wire logic                         o_reg_rvalid,
    input wire logic                         i_conv_pll_locked,
    input wire dac_ctrl_pkg::power_down_s    o_power_down,
    input wire logic [`DELAY_TRIM_WIDTH-1:0] o_group_delay_code,
    input wire dac_ctrl_pkg::pll_event_s     o_pll_event
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    // ==========================================
    // Register port and derived outputs
    rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
    rd_idle_a: assert property (!i_reg_rd |=> !o_reg_rvalid && o_reg_rdata == 8'h00)
        else $error("read data without a read");
    unmapped_zero_a: assert property (i_reg_rd && i_reg_addr == 12'h015 |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    ctrl_reserved_a: assert property (i_reg_rd && i_reg_addr == 12'h013 |=> !o_reg_rdata[7])
        else $error("control reserved bit set");
    trim_reserved_a: assert property (i_reg_rd && i_reg_addr == 12'h014 |=> o_reg_rdata[7:4] == 4'h0)
        else $error("trim reserved bits set");
    mask_readback_a: assert property (i_reg_wr && !i_reg_rd && i_reg_addr == 12'h012 ##1
        i_reg_rd && !i_reg_wr && i_reg_addr == 12'h012 |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("mask readback wrong");
    trim_follow_a: assert property (i_reg_wr && i_reg_addr == 12'h014 |->
        ##2 o_group_delay_code == ($past(i_reg_wdata, 2) & 8'h0f)) else $error("delay code stale");
    reset_state_a: assert property ($fell(i_reset) |-> o_power_down == 5'h1f &&
        o_group_delay_code == 4'h8) else $error("reset outputs wrong");
    lock_pulse_a: assert property (o_pll_event.conv_pll_locked |=> !o_pll_event.conv_pll_locked
        && $past(i_conv_pll_locked, 2)) else $error("lock event wrong");
    unlock_cause_a: assert property (o_pll_event.conv_pll_unlock |->
        !$past(i_conv_pll_locked, 2)) else $error("unlock event without cause");
    cover property (o_pll_event.conv_pll_locked);
    cover property (o_reg_rvalid && o_reg_rdata != 8'h00);
    cover property (o_power_down.conv == 4'hf);
endmodule // dac_ctrl_asserts

bind dac_tx_power_pa_control dac_ctrl_asserts dac_ctrl_asserts_inst (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_conv_pll_locked(i_conv_pll_locked),
    .o_power_down(o_power_down), .o_group_delay_code(o_group_delay_code),
    .o_pll_event(o_pll_event));

//--- tb/host_model.sv
// Register host model driving the byte port of the control bank
`timescale 1ns/1ps
module host_model (
    input  wire logic        i_core_clk,
    input  wire logic [7:0]  i_reg_rdata,
    input  wire logic        i_reg_rvalid,
    output logic      [11:0] o_reg_addr = 12'h000,
    output logic             o_reg_wr = 1'b0,
    output logic             o_reg_rd = 1'b0,
    output logic      [7:0]  o_reg_wdata = 8'h00
);
    // Released lines flip to the inverse on each call, so two idles in a row bring a stale address back
    task automatic idle(input int n);
        @(negedge i_core_clk);
        {o_reg_rd, o_reg_wr, o_reg_addr, o_reg_wdata} = {2'b00, ~o_reg_addr, ~o_reg_wdata};
        repeat (n) @(negedge i_core_clk);
    endtask
    // Strobe stays up after a write so a read can follow back to back
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        {o_reg_rd, o_reg_wr, o_reg_addr, o_reg_wdata} = {2'b01, a, d};
        @(posedge i_core_clk);
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic v);
        @(negedge i_core_clk);
        {o_reg_rd, o_reg_wr, o_reg_addr} = {2'b10, a};
        // Answer stands from the edge that took the strobe; take it mid-cycle, clear of that edge
        idle(0);
        d = i_reg_rdata;
        v = i_reg_rvalid;
    endtask
endmodule // host_model

//--- tb/dac_tx_power_pa_control_tb_top.sv
// Self-checking bench for the converter control bank
`timescale 1ns/1ps
module dac_tx_power_pa_control_tb_top;
    logic        i_core_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [11:0] addr;
    logic        wr, rd, rvalid, amp_en;
    logic [7:0]  wdata, rdata;
    logic        pin_a = 1'b1, pin_b = 1'b1, prot_err = 1'b0, tx_on = 1'b0, blank_on = 1'b0;
    logic        conv_lock = 1'b0, link_lock = 1'b0;
    logic [1:0]  tx_en;
    logic [3:0]  delay;
    dac_ctrl_pkg::power_down_s power_down;
    dac_ctrl_pkg::pll_event_s  pll_ev;
    int          bad_count = 0, num_checks = 0, cycles = 0;
    logic [7:0]  d;
    logic        v;
    dac_tx_power_pa_control dac_tx_power_pa_control_inst (.i_core_clk(i_core_clk),
        .i_reset(i_reset), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_tx_enable_input_a(pin_a),
        .i_tx_enable_input_b(pin_b), .i_amp_protect_error(prot_err), .i_tx_machine_amp_on(tx_on),
        .i_blanking_amp_on(blank_on), .i_conv_pll_locked(conv_lock), .i_link_pll_locked(link_lock),
        .o_power_down(power_down), .o_amp_enable(amp_en), .o_tx_enable(tx_en),
        .o_group_delay_code(delay), .o_pll_event(pll_ev));
    host_model host_model_inst (.i_core_clk(i_core_clk), .i_reg_rdata(rdata),
        .i_reg_rvalid(rvalid), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata));
    // ==========================================
    // Checking and closing
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial forever #4 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    // Six cycles covers the pin synchronisers plus the output register
    task automatic drive(input logic [4:0] p);
        host_model_inst.idle(0);
        {pin_b, pin_a, prot_err, tx_on, blank_on} = p;
        host_model_inst.idle(5);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset_values;
        logic [11:0] ofs [5] = '{12'h011, 12'h012, 12'h013, 12'h014, 12'h01f};
        logic [7:0]  rst [5] = '{8'hf8, 8'h00, 8'h20, 8'h08, 8'h00};
        for (int k = 0; k < 5; k++) begin
            host_model_inst.rd(ofs[k], d, v);
            chk(d, rst[k]);
            chk({7'h00, v}, 8'h01);
        end
        chk({3'h0, power_down}, 8'h1f);
    endtask
    task automatic t_masks;
        host_model_inst.wr(12'h011, 8'h00);
        host_model_inst.wr(12'h012, 8'hc0);
        host_model_inst.rd(12'h012, d, v);
        chk(d, 8'hc0);
        drive(5'b10000);
        chk({3'h0, power_down}, 8'h03);
        drive(5'b01000);
        chk({3'h0, power_down}, 8'h0c);
        host_model_inst.wr(12'h011, 8'hc0);
        drive(5'b01000);
        chk({3'h0, power_down}, 8'h1d);
        host_model_inst.wr(12'h012, 8'h00);
        drive(5'b01000);
        chk({3'h0, power_down}, 8'h11);
    endtask
    task automatic t_override;
        host_model_inst.wr(12'h011, 8'h00);
        host_model_inst.wr(12'h012, 8'hc0);
        host_model_inst.wr(12'h013, 8'h02);
        drive(5'b11000);
        chk({6'h0, tx_en}, 8'h00);
        chk({3'h0, power_down}, 8'h0f);
        host_model_inst.wr(12'h013, 8'hff);
        host_model_inst.wr(12'h015, 8'hff);
        host_model_inst.rd(12'h013, d, v);
        chk(d, 8'h7f);
        host_model_inst.rd(12'h015, d, v);
        chk(d, 8'h00);
        drive(5'b00000);
        chk({6'h0, tx_en}, 8'h03);
        chk({3'h0, power_down}, 8'h00);
    endtask
    task automatic t_amp;
        logic [11:0] cs [11] = '{12'h205, 12'h200, 12'h401, 12'h408, 12'h103, 12'h104,
                                 12'h0c9, 12'h086, 12'h006, 12'h6cc, 12'h3c7};
        for (int k = 0; k < 11; k++) begin
            host_model_inst.wr(12'h013, cs[k][11:4]);
            drive({2'b11, cs[k][3:1]});
            chk({7'h0, amp_en}, {7'h0, cs[k][0]});
        end
    endtask
    task automatic t_delay;
        logic [7:0] vals [3] = '{8'hff, 8'h00, 8'h07};
        for (int k = 0; k < 3; k++) begin
            host_model_inst.wr(12'h014, vals[k]);
            host_model_inst.rd(12'h014, d, v);
            chk(d, vals[k] & 8'h0f);
            drive(5'b11000);
            chk({4'h0, delay}, vals[k] & 8'h0f);
        end
    endtask
    task automatic t_events;
        logic [15:0] ev [8] = '{16'h3014, 16'h3030, 16'h3028, 16'h3000,
                                16'h0c10, 16'h0c31, 16'h0c12, 16'h0c00};
        logic [3:0]  seen;
        for (int k = 0; k < 8; k++) begin
            host_model_inst.wr(12'h01f, ev[k][15:8]);
            host_model_inst.idle(0);
            {link_lock, conv_lock} = ev[k][5:4];
            seen = 4'h0;
            // One-cycle pulses are caught mid-cycle, never in the edge that launches them
            repeat (8) @(negedge i_core_clk) seen = seen | pll_ev;
            chk({4'h0, seen}, {4'h0, ev[k][3:0]});
        end
    endtask
    initial begin
        repeat (8) @(negedge i_core_clk);
        i_reset = 1'b0;
        t_reset_values();
        t_masks();
        t_override();
        t_amp();
        t_delay();
        t_events();
        tally_and_finish();
    end
endmodule // dac_tx_power_pa_control_tb_top
